// *** bench/dra_host_model.sv ***
// Purpose: host controller model that drives the request line and reads alarm pins
// Assumes: pull-ups on the host side; pins are open collector
// Notes:   a conducting transistor pulls its line low
module dra_host_model (
   // clock
   input  wire logic       clk,
   // open collector pins from the drive
   input  wire logic       code0_oe_n,
   input  wire logic       code1_oe_n,
   input  wire logic       code2_oe_n,
   input  wire logic       alarm_oe_n,
   // request line toward the drive
   output logic            req,
   // what the host decodes from the lines
   output logic [2:0]      code_on,
   output logic            alarm_on
);
   timeunit 1ns;
   timeprecision 1ps;
   // line levels: off transistor lets the pull-up win, never left floating
   wire logic [3:0] line_lvl = {alarm_oe_n, code2_oe_n, code1_oe_n, code0_oe_n};
   // conducting means low line, so the host inverts
   assign code_on  = ~line_lvl[2:0];
   assign alarm_on = ~line_lvl[3];
   // battery voltage is not watched here, the drive has no pin for it
   // swap is only done after three minutes powered, so no drive logic involved
   initial req = 1'b0;
   // on-then-off cycle: high for hi cycles, then two low cycles
   // the bench asks for a short hi only to see the restart refused
   task cycle_req(input int hi);
      @(posedge clk) req <= 1'b1;
      repeat (hi) @(posedge clk);
      req <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
endmodule

// *** bench/drive_alarm_reporting_test.sv ***
// Purpose: self-checking bench of the drive alarm block over its register bus
// Assumes: request line hold shortened to 8 cycles
// Notes:   pins are judged through the host model's pulled-up lines
module drive_alarm_reporting_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 8;  // short hold so the run stays brief
   // clock, reset and bus master state
   logic clk = 1'b0, resetn = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [4:0]  wb_adr = 5'h00;
   logic [31:0] wb_dat = 32'h0, wb_q, dat_o;
   logic        ack, irq, restart, req, alarm_on;
   // fault sources, one bit per overcurrent cause
   logic [2:0]  oc_src = 3'h0;
   logic torn = 1'b0, range_err = 1'b0, enc_abs = 1'b0, hot = 1'b0, pos_ctl = 1'b0;
   logic c0, c1, c2, ao;
   logic [2:0]  code_on;
   int err_total = 0, compares = 0, restarts = 0, cyc_cnt = 0;
   always #12.5 clk = ~clk;
   dra_top #(.REQ_HOLD(HOLD)) dut (
      .clk(clk), .resetn(resetn),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .param_write_torn(torn), .param_range_err(range_err),
      .encoder_is_absolute(enc_abs), .ground_fault(oc_src[0]),
      .transistor_fault(oc_src[1]), .current_fb_fault(oc_src[2]),
      .temp_over_90c(hot), .position_control(pos_ctl),
      .absolute_data_request(req), .encoder_acq_restart(restart),
      .alarm_code_line_0_oe_n(c0), .alarm_code_line_1_oe_n(c1),
      .alarm_code_line_2_oe_n(c2), .alarm_out_oe_n(ao), .irq(irq));
   dra_host_model host (
      .clk(clk), .code0_oe_n(c0), .code1_oe_n(c1), .code2_oe_n(c2),
      .alarm_oe_n(ao), .req(req), .code_on(code_on), .alarm_on(alarm_on));
   // restart pulses stand one cycle, so count them at every edge
   always @(posedge clk) begin
      if (restart === 1'b1) restarts++;
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         err_total++;  // hang guard
         final_report();
      end
   end
   // verdict and end of run
   task final_report();
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one classic cycle; ack sampled at the edge, then release
   task xfer(input logic we, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      wb_q = dat_o;
      if (n >= 50) chk(32'h1, 32'h0, "no ack");
      wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [4:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0);
      chk(wb_q, exp, what);
   endtask
   // live alarm word: flags, conducting code lines, conducting alarm output
   function automatic logic [31:0] aw(logic [3:0] f, logic [2:0] c, logic a);
      return {24'h0, a, c, f};
   endfunction
   // alarm state seen by the host and by software must agree
   task state(input logic [3:0] f, input logic [2:0] c, input logic a);
      repeat (4) @(posedge clk);
      chk({28'h0, code_on, alarm_on}, {28'h0, c, a}, "pins");
      rd(dra_pkg::ADR_ALARM, aw(f, c, a), "alarm word");
   endtask
   // power cycle, with the torn-write level offered at release
   task power(input logic t);
      @(posedge clk) resetn <= 1'b0;
      torn <= t;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      torn <= 1'b0;
   endtask
   task pulse_oc(input int i);
      @(posedge clk) oc_src[i] <= 1'b1;
      @(posedge clk) oc_src[i] <= 1'b0;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      // healthy drive after reset, register reset values, unmapped place
      state(4'h0, dra_pkg::CODE_ON_NONE, dra_pkg::ALM_ON_OK);
      rd(dra_pkg::ADR_FSW, 32'h0, "fsw reset");
      rd(dra_pkg::ADR_IMASK, 32'h0, "imask reset");
      rd(5'h14, 32'h0, "unmapped");
      // every overcurrent cause, one at a time
      for (int i = 0; i < 3; i++) begin
         wr(dra_pkg::ADR_IMASK, 32'h0);
         pulse_oc(i);
         state(4'h8, dra_pkg::CODE_ON_OC, dra_pkg::ALM_ON_FAULT);
         chk({31'h0, irq}, 32'h0, "irq masked");
         wr(dra_pkg::ADR_IMASK, 32'h8);
         @(posedge clk);
         chk({31'h0, irq}, 32'h1, "irq raised");
         rd(dra_pkg::ADR_ISTAT, 32'h8, "istat event");
         // hot power stage refuses the clear, code stays put
         hot <= 1'b1;
         wr(dra_pkg::ADR_CTRL, 32'h1);
         state(4'h8, dra_pkg::CODE_ON_OC, dra_pkg::ALM_ON_FAULT);
         hot <= 1'b0;
         wr(dra_pkg::ADR_CTRL, 32'h1);
         state(4'h0, dra_pkg::CODE_ON_NONE, dra_pkg::ALM_ON_OK);
         wr(dra_pkg::ADR_ISTAT, 32'h8);
         @(posedge clk);
         chk({31'h0, irq}, 32'h0, "irq cleared");
      end
      // out-of-range parameter goes dark, alarm reset clears it
      @(posedge clk) range_err <= 1'b1;
      @(posedge clk) range_err <= 1'b0;
      state(4'h2, dra_pkg::CODE_ON_DARK, dra_pkg::ALM_ON_FAULT);
      wr(dra_pkg::ADR_CTRL, 32'h1);
      state(4'h0, dra_pkg::CODE_ON_NONE, dra_pkg::ALM_ON_OK);
      // absolute select is fine with an absolute encoder
      enc_abs <= 1'b1;
      wr(dra_pkg::ADR_FSW, 32'h4000);
      state(4'h0, dra_pkg::CODE_ON_NONE, dra_pkg::ALM_ON_OK);
      enc_abs <= 1'b0;
      state(4'h4, dra_pkg::CODE_ON_DARK, dra_pkg::ALM_ON_FAULT);
      wr(dra_pkg::ADR_FSW, 32'h0);
      wr(dra_pkg::ADR_CTRL, 32'h1);
      state(4'h4, dra_pkg::CODE_ON_DARK, dra_pkg::ALM_ON_FAULT);
      power(1'b0);
      state(4'h0, dra_pkg::CODE_ON_NONE, dra_pkg::ALM_ON_OK);
      // interrupted parameter write shows up at the next power-up
      power(1'b1);
      state(4'h1, dra_pkg::CODE_ON_DARK, dra_pkg::ALM_ON_FAULT);
      wr(dra_pkg::ADR_CTRL, 32'h1);
      state(4'h1, dra_pkg::CODE_ON_DARK, dra_pkg::ALM_ON_FAULT);
      power(1'b0);
      // request line: a rise restarts only after a long high phase
      host.cycle_req(HOLD + 2);
      host.cycle_req(HOLD + 2);
      host.cycle_req(HOLD - 4);
      host.cycle_req(HOLD + 2);
      repeat (3) @(posedge clk);
      chk(restarts, 2, "restarts speed mode");
      wr(dra_pkg::ADR_FSW, 32'h2);
      host.cycle_req(HOLD + 2);
      wr(dra_pkg::ADR_FSW, 32'h0);
      pos_ctl <= 1'b1;
      host.cycle_req(HOLD + 2);
      pos_ctl <= 1'b0;
      host.cycle_req(HOLD + 2);
      repeat (3) @(posedge clk);
      chk(restarts, 3, "restarts other modes");
      final_report();
   end
endmodule

// *** src/dra_alarm_if.sv ***
// Purpose: carries live alarm flags to the encoder and pin codes back
// Assumes: one clock domain
// Notes:   code_on and alarm_on are decoded from the encoder state
interface dra_alarm_if;
   logic [dra_pkg::NUM_AL-1:0] active;    // live alarm flags
   logic [2:0]                 code_on;   // code lines that conduct
   logic                       alarm_on;  // alarm output conducts
   dra_pkg::dra_show_t         show;      // alarm now presented
   // flag producer
   modport top (output active, input code_on, alarm_on, show);
   // pin encoder
   modport enc (input active, output code_on, alarm_on, show);
endinterface

// *** src/dra_encode.sv ***
// Purpose: picks the alarm shown on the pins and encodes it
// Assumes: flags are sticky until a legal clear
// Notes:   dark alarms preempt a held overcurrent
module dra_encode (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // alarm carrier
   dra_alarm_if.enc  al
);
   dra_pkg::dra_show_t show;       // presented alarm
   dra_pkg::dra_show_t next_show;  // choice for next cycle

   // priority pick; overcurrent shown while its flag stands and no dark alarm flag is up
   always_comb begin
      if (al.active[dra_pkg::AL_PARAM_BREAK]) begin
         next_show = dra_pkg::DRA_SHOW_BREAK;
      end else if (al.active[dra_pkg::AL_PARAM_RANGE]) begin
         next_show = dra_pkg::DRA_SHOW_RANGE;
      end else if (al.active[dra_pkg::AL_ABS_DATA]) begin
         next_show = dra_pkg::DRA_SHOW_ABS;
      end else if (al.active[dra_pkg::AL_OVERCUR]) begin
         next_show = dra_pkg::DRA_SHOW_OC;
      end else begin
         next_show = dra_pkg::DRA_SHOW_NONE;
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) show <= dra_pkg::DRA_SHOW_NONE;
      else         show <= next_show;
   end

   // encode state onto conduct bits
   always_comb begin
      case (show)
         dra_pkg::DRA_SHOW_NONE: begin
            al.code_on  = dra_pkg::CODE_ON_NONE;
            al.alarm_on = dra_pkg::ALM_ON_OK;
         end
         dra_pkg::DRA_SHOW_OC: begin
            al.code_on  = dra_pkg::CODE_ON_OC;
            al.alarm_on = dra_pkg::ALM_ON_FAULT;
         end
         default: begin
            al.code_on  = dra_pkg::CODE_ON_DARK;
            al.alarm_on = dra_pkg::ALM_ON_FAULT;
         end
      endcase
   end
   assign al.show = show;

   // overcurrent stays shown while only its flag is up
   oc_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (show == dra_pkg::DRA_SHOW_OC && al.active == 4'h8) |=> show == dra_pkg::DRA_SHOW_OC)
      else $error("overcurrent display not held");
endmodule

// *** src/dra_pkg.sv ***
// Purpose: shared constants and types of the drive alarm reporting block
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register bus
// Notes:   all offsets are byte addresses of aligned words
package dra_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ      = 40_000_000;  // system clock rate
   localparam int unsigned REQ_HOLD_MS = 1300;        // least high time of request line
   // least time rounds up to whole cycles; product needs 64 bits
   localparam longint unsigned REQ_HOLD_CYC64 =
      (longint'(REQ_HOLD_MS) * longint'(CLK_HZ) + 64'd999) / 64'd1000;
   localparam int unsigned REQ_HOLD_CYC = 32'(REQ_HOLD_CYC64);
   localparam int          REQ_CNT_W    = 26;          // counter width for hold time
   // register byte offsets
   localparam logic [4:0] ADR_CTRL  = 5'h00;  // alarm reset request
   localparam logic [4:0] ADR_FSW   = 5'h04;  // function select word
   localparam logic [4:0] ADR_ALARM = 5'h08;  // live alarm state
   localparam logic [4:0] ADR_ISTAT = 5'h0C;  // sticky event flags, write one clears
   localparam logic [4:0] ADR_IMASK = 5'h10;  // event mask
   // field positions
   localparam int CTRL_RESET_BIT   = 0;   // write one: alarm reset request
   localparam int FSW_REQ_MODE_BIT = 1;   // 0: request line restarts acquisition
   localparam int FSW_ABS_SEL_BIT  = 14;  // 1: absolute encoder selected
   localparam int ALM_CODE_LSB     = 4;   // code line conduct bits in alarm word
   localparam int ALM_OUT_BIT      = 7;   // alarm output conduct bit in alarm word
   // reset values
   localparam logic [15:0] FSW_RESET   = 16'h0000;
   localparam logic [3:0]  IMASK_RESET = 4'h0;
   // alarm flag indices
   localparam int NUM_AL         = 4;
   localparam int AL_PARAM_BREAK = 0;  // stored parameter breakdown
   localparam int AL_PARAM_RANGE = 1;  // parameter setting error
   localparam int AL_ABS_DATA    = 2;  // absolute data error
   localparam int AL_OVERCUR     = 3;  // overcurrent
   // pin encodings, one means transistor conducts
   localparam logic [2:0] CODE_ON_NONE = 3'h0;
   localparam logic [2:0] CODE_ON_DARK = 3'h0;  // breakdown, setting and abs data
   localparam logic [2:0] CODE_ON_OC   = 3'h1;  // only first code line conducts
   localparam logic       ALM_ON_OK    = 1'b1;  // healthy drive: output conducts
   localparam logic       ALM_ON_FAULT = 1'b0;
   // shown alarm
   typedef enum logic [2:0] {
      DRA_SHOW_NONE, DRA_SHOW_BREAK, DRA_SHOW_RANGE, DRA_SHOW_ABS, DRA_SHOW_OC
   } dra_show_t;
endpackage

// *** src/dra_top.sv ***
// Purpose: alarm detection, clear policy and pin encoding of a servo drive
// Assumes: inputs synchronous to clk; resetn low is a power cycle
// Notes:   pins are open collector; oe_n low means the transistor conducts
module dra_top #(
   parameter int unsigned REQ_HOLD = dra_pkg::REQ_HOLD_CYC  // request line least high time
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // fault sources
   input  wire logic        param_write_torn,
   input  wire logic        param_range_err,
   input  wire logic        encoder_is_absolute,
   input  wire logic        ground_fault,
   input  wire logic        transistor_fault,
   input  wire logic        current_fb_fault,
   input  wire logic        temp_over_90c,
   // encoder acquisition
   input  wire logic        position_control,
   input  wire logic        absolute_data_request,
   output logic             encoder_acq_restart,
   // open collector alarm pins
   output logic             alarm_code_line_0_oe_n,
   output logic             alarm_code_line_1_oe_n,
   output logic             alarm_code_line_2_oe_n,
   output logic             alarm_out_oe_n,
   // interrupt
   output logic             irq
);
   // refuse hold times the counter cannot reach
   if (REQ_HOLD < 1 || REQ_HOLD >= (1 << dra_pkg::REQ_CNT_W)) begin : g_chk
      $error("REQ_HOLD out of range");
   end

   // carrier to the encoder
   dra_alarm_if al ();

   // register state
   logic [15:0]               fsw;       // function select word
   logic [dra_pkg::NUM_AL-1:0] active;   // sticky alarm flags
   logic [dra_pkg::NUM_AL-1:0] act_d;    // flags one cycle back
   logic [dra_pkg::NUM_AL-1:0] istat;    // event flags
   logic [dra_pkg::NUM_AL-1:0] imask;    // event mask
   logic                      boot_done; // power-up sample taken
   // request line tracking
   logic                      req_d;     // request line one cycle back
   logic [dra_pkg::REQ_CNT_W-1:0] req_cnt; // high time count, saturating
   logic                      req_armed; // last high phase was long enough

   // bus decode
   wire logic       wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;  // new access
   wire logic       wb_wr   = wb_req & wb_we_i;
   wire logic [4:0] adr     = {wb_adr_i[4:2], 2'b00};           // word aligned
   wire logic       hit_ctl = adr == dra_pkg::ADR_CTRL;
   wire logic       hit_fsw = adr == dra_pkg::ADR_FSW;
   wire logic       hit_alm = adr == dra_pkg::ADR_ALARM;
   wire logic       hit_ist = adr == dra_pkg::ADR_ISTAT;
   wire logic       hit_imk = adr == dra_pkg::ADR_IMASK;
   // write strobes per register, low lane carries every narrow field
   wire logic       wr_ctl  = wb_wr & hit_ctl & wb_sel_i[0];
   wire logic       wr_ist  = wb_wr & hit_ist & wb_sel_i[0];
   wire logic       wr_imk  = wb_wr & hit_imk & wb_sel_i[0];
   wire logic       wr_fs0  = wb_wr & hit_fsw & wb_sel_i[0];
   wire logic       wr_fs1  = wb_wr & hit_fsw & wb_sel_i[1];
   // alarm reset request, a one-cycle pulse
   wire logic       alm_rst = wr_ctl & wb_dat_i[dra_pkg::CTRL_RESET_BIT];

   // fault detection terms
   wire logic set_break = ~boot_done & param_write_torn;
   wire logic set_range = param_range_err;
   wire logic set_abs   = fsw[dra_pkg::FSW_ABS_SEL_BIT] & ~encoder_is_absolute;
   wire logic set_oc    = ground_fault | transistor_fault | current_fb_fault;
   // clear terms; breakdown has no software clear
   wire logic clr_range = alm_rst;
   wire logic clr_oc    = alm_rst & ~temp_over_90c;

   // next values of the flags; a set in the clear cycle wins
   wire logic [dra_pkg::NUM_AL-1:0] next_active = {
      set_oc    | (active[dra_pkg::AL_OVERCUR]     & ~clr_oc),
      set_abs   |  active[dra_pkg::AL_ABS_DATA],
      set_range | (active[dra_pkg::AL_PARAM_RANGE] & ~clr_range),
      set_break |  active[dra_pkg::AL_PARAM_BREAK]
   };
   // new alarms become interrupt events
   wire logic [dra_pkg::NUM_AL-1:0] rise   = active & ~act_d;
   wire logic [dra_pkg::NUM_AL-1:0] ist_cl = wr_ist ? wb_dat_i[dra_pkg::NUM_AL-1:0] : '0;
   wire logic [dra_pkg::NUM_AL-1:0] next_istat = rise | (istat & ~ist_cl);

   // request line edges and mode
   wire logic req_fall = req_d & ~absolute_data_request;
   wire logic req_rise = ~req_d & absolute_data_request;
   wire logic req_mode = ~position_control & ~fsw[dra_pkg::FSW_REQ_MODE_BIT];
   wire logic req_long = req_cnt >= dra_pkg::REQ_CNT_W'(REQ_HOLD);
   wire logic next_restart = req_rise & req_armed & req_mode;

   // read data selection
   wire logic [31:0] alm_word = {
      24'h000000,
      al.alarm_on,
      al.code_on,
      active
   };
   wire logic [31:0] rd_data =
      hit_ctl ? 32'h00000000 :
      hit_fsw ? {16'h0000, fsw} :
      hit_alm ? alm_word :
      hit_ist ? {28'h0000000, istat} :
      hit_imk ? {28'h0000000, imask} :
      32'h00000000;                       // unmapped reads give zero

   // flags out to the encoder
   assign al.active = active;

   // encoder picks and holds the shown alarm
   dra_encode u_enc (
      .clk    (clk),
      .resetn (resetn),
      .al     (al)
   );

   // bus answer: one wait state, ack for exactly one cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h00000000;
      end
   end

   // function select word, byte lanes honoured
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fsw <= dra_pkg::FSW_RESET;
      end else begin
         if (wr_fs0) fsw[7:0]  <= wb_dat_i[7:0];
         if (wr_fs1) fsw[15:8] <= wb_dat_i[15:8];
      end
   end

   // interrupt mask
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)     imask <= dra_pkg::IMASK_RESET;
      else if (wr_imk) imask <= wb_dat_i[dra_pkg::NUM_AL-1:0];
   end

   // power-up sample of the storage state, taken once after release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) boot_done <= 1'b0;
      else         boot_done <= 1'b1;
   end

   // alarm flags; only reset clears the absolute and breakdown flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         active <= '0;
         act_d  <= '0;
      end else begin
         active <= next_active;
         act_d  <= active;
      end
   end

   // sticky events and the level interrupt
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         istat <= '0;
         irq   <= 1'b0;
      end else begin
         istat <= next_istat;
         irq   <= |(next_istat & imask);
      end
   end

   // request line high-time counter, cleared while low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_d   <= 1'b0;
         req_cnt <= '0;
      end else begin
         req_d <= absolute_data_request;
         if (!absolute_data_request) req_cnt <= '0;
         else if (!req_long)         req_cnt <= req_cnt + 1'b1;
      end
   end

   // a short high phase disarms; rearm needs a fresh long one
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_armed           <= 1'b0;
         encoder_acq_restart <= 1'b0;
      end else begin
         if (req_fall)      req_armed <= req_long;
         else if (req_rise) req_armed <= 1'b0;
         encoder_acq_restart <= next_restart;
      end
   end

   // open collector pins: low enable lets the transistor conduct
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         alarm_code_line_0_oe_n <= 1'b1;
         alarm_code_line_1_oe_n <= 1'b1;
         alarm_code_line_2_oe_n <= 1'b1;
         alarm_out_oe_n         <= 1'b1;
      end else begin
         alarm_code_line_0_oe_n <= ~al.code_on[0];
         alarm_code_line_1_oe_n <= ~al.code_on[1];
         alarm_code_line_2_oe_n <= ~al.code_on[2];
         alarm_out_oe_n         <= ~al.alarm_on;
      end
   end

   // all four pins off together
   wire logic pins_dark = alarm_code_line_0_oe_n & alarm_code_line_1_oe_n &
                          alarm_code_line_2_oe_n & alarm_out_oe_n;

   // alarm output pin follows the encoder one cycle later
   pin_track_a: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> alarm_out_oe_n == !$past(al.alarm_on))
      else $error("alarm output pin does not follow encoder");

   // breakdown darkens every pin within two cycles
   break_dark_a: assert property (@(posedge clk) disable iff (!resetn)
      active[dra_pkg::AL_PARAM_BREAK] |-> ##2 pins_dark)
      else $error("pins not dark during parameter breakdown");

   // setting error darkens every pin
   range_dark_a: assert property (@(posedge clk) disable iff (!resetn)
      active[dra_pkg::AL_PARAM_RANGE] [*3] |-> pins_dark)
      else $error("pins not dark during setting error");

   // torn write at power-up raises breakdown
   boot_break_a: assert property (@(posedge clk) disable iff (!resetn)
      (resetn && !boot_done && param_write_torn) |=> active[dra_pkg::AL_PARAM_BREAK])
      else $error("torn parameter write not flagged");

   // out-of-range parameter raises setting error
   range_set_a: assert property (@(posedge clk) disable iff (!resetn)
      param_range_err |=> active[dra_pkg::AL_PARAM_RANGE])
      else $error("setting error not raised");

   // absolute select with incremental encoder
   abs_sel_a: assert property (@(posedge clk) disable iff (!resetn)
      (fsw[dra_pkg::FSW_ABS_SEL_BIT] && !encoder_is_absolute) |=> active[dra_pkg::AL_ABS_DATA])
      else $error("absolute data error not raised");

   // absolute data error survives any alarm reset
   abs_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      active[dra_pkg::AL_ABS_DATA] |=> active[dra_pkg::AL_ABS_DATA])
      else $error("absolute data error cleared without power cycle");

   // restart only on a qualified rise in the right mode
   req_restart_a: assert property (@(posedge clk) disable iff (!resetn)
      encoder_acq_restart |-> $past(req_rise) && $past(req_mode) && $past(req_armed))
      else $error("acquisition restart without qualified request cycle");

   // overcurrent code: only first code line conducts
   oc_code_a: assert property (@(posedge clk) disable iff (!resetn)
      (active == 4'h8) [*3] |-> !alarm_code_line_0_oe_n && alarm_code_line_1_oe_n
                                && alarm_code_line_2_oe_n && alarm_out_oe_n)
      else $error("overcurrent code wrong on pins");

   // hot power stage blocks the overcurrent clear
   oc_hot_a: assert property (@(posedge clk) disable iff (!resetn)
      (active[dra_pkg::AL_OVERCUR] && temp_over_90c) |=> active[dra_pkg::AL_OVERCUR])
      else $error("overcurrent cleared while hot");

   // no alarm: alarm output conducts, code lines off
   idle_ok_a: assert property (@(posedge clk) disable iff (!resetn)
      (active == 4'h0) [*3] |-> !alarm_out_oe_n && alarm_code_line_0_oe_n
                                && alarm_code_line_1_oe_n && alarm_code_line_2_oe_n)
      else $error("alarm indicated with no alarm active");

   // code lines follow the encoder one cycle later
   code_track_a: assert property (@(posedge clk) disable iff (!resetn)
      $past(resetn) |-> {alarm_code_line_2_oe_n, alarm_code_line_1_oe_n,
                         alarm_code_line_0_oe_n} == ~$past(al.code_on))
      else $error("code line pins do not follow encoder");

   // absolute data error darkens every pin
   abs_dark_a: assert property (@(posedge clk) disable iff (!resetn)
      active[dra_pkg::AL_ABS_DATA] |-> ##2 pins_dark)
      else $error("pins not dark during absolute data error");

   // breakdown has no software clear
   break_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      active[dra_pkg::AL_PARAM_BREAK] |=> active[dra_pkg::AL_PARAM_BREAK])
      else $error("parameter breakdown cleared without power cycle");

   // setting error stays until an alarm reset
   range_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      (active[dra_pkg::AL_PARAM_RANGE] && !alm_rst) |=> active[dra_pkg::AL_PARAM_RANGE])
      else $error("setting error dropped without alarm reset");

   // overcurrent stays until an alarm reset
   oc_keep_a: assert property (@(posedge clk) disable iff (!resetn)
      (active[dra_pkg::AL_OVERCUR] && !alm_rst) |=> active[dra_pkg::AL_OVERCUR])
      else $error("overcurrent dropped without alarm reset");

   // any overcurrent cause raises the flag
   oc_set_a: assert property (@(posedge clk) disable iff (!resetn)
      (resetn && (ground_fault || transistor_fault || current_fb_fault)) |=> active[3])
      else $error("overcurrent not raised");

   // restart is a single-cycle pulse
   restart_one_a: assert property (@(posedge clk) disable iff (!resetn)
      encoder_acq_restart |=> !encoder_acq_restart)
      else $error("acquisition restart longer than one cycle");

   // no restart outside speed mode with the line mode bit clear
   restart_mode_a: assert property (@(posedge clk) disable iff (!resetn)
      (req_rise && !req_mode) |=> !encoder_acq_restart)
      else $error("acquisition restart in wrong mode");

   // a short high phase leaves the line disarmed
   short_hold_a: assert property (@(posedge clk) disable iff (!resetn)
      (req_fall && !req_long) |=> !req_armed)
      else $error("short request high phase armed a restart");
endmodule
